// ===== verilog/psic_top.sv
// PHY status summary, interrupt control and event logic behind the management interface

// Summary of operation
// - Status bit 2 reports full duplex
// - Status bit 1 reports 10 Mb/s speed
// - Status bit 0 mirrors link, not read-cleared
// - Control bits 15:3 ignore writes, read zero
// - Control bit 2 forces interrupt while set
// - Control bit 1 gates event interrupts globally
// - Control bit 0 selects pin output role
// - Seven listed event sources feed interrupts
// - Event status sets even when not enabled
// - Event register read clears pending interrupt unless control bit 2 forces it or an enabled event arrives in the read cycle
module psic_top #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire psic_pkg::psic_link_t i_link,
    input wire logic i_lq_event,
    input wire logic i_ed_event,
    input wire logic i_ctr_half_event,
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe,
    output logic o_powerdown_req
);

    // Pin synchronisers
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic mdio_s1_q, mdio_s2_q;
    logic pin_s1_q, pin_s2_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            mdc_s1_q <= i_mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            mdio_s1_q <= i_mdio;
            mdio_s2_q <= mdio_s1_q;
            pin_s1_q <= i_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    wire logic mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // Frame decode
    psic_pkg::psic_mdio_st_t st_q, st_d;
    logic [5:0] cnt_q, cnt_d;
    logic [12:0] hdr_q, hdr_d;
    logic [15:0] sh_q, sh_d;
    logic mo_q, mo_d, moe_q, moe_d;
    logic rd_q;
    logic [4:0] regad_q;

    wire logic [12:0] hdr_full = {hdr_q[11:0], mdio_s2_q};
    wire logic [1:0] hdr_op = hdr_full[11:10];
    wire logic [4:0] hdr_phy = hdr_full[9:5];
    wire logic [4:0] hdr_reg = hdr_full[4:0];
    wire logic hdr_done = mdc_rise && st_q == psic_pkg::PSIC_HDR
        && cnt_q == psic_pkg::PSIC_HDR_LAST;
    wire logic hdr_ok = hdr_full[12] && hdr_phy == PHY_ADDR;
    wire logic rd_go = hdr_done && hdr_ok && hdr_op == psic_pkg::PSIC_OP_RD;
    wire logic wr_go = hdr_done && hdr_ok && hdr_op == psic_pkg::PSIC_OP_WR;
    wire logic wr_commit = mdc_rise && st_q == psic_pkg::PSIC_WDATA && cnt_q == 6'h00;
    wire logic [15:0] wr_word = {sh_q[14:0], mdio_s2_q};

    // Registers and event sources
    logic [2:0] ctl_q;
    psic_pkg::psic_link_t link_q;
    logic pend_q, pin_oe_q, pdn_q;
    logic [psic_pkg::PSIC_EV_N-1:0] ev_sts, ev_en;
    logic ev_any;

    wire logic ctl_oe = ctl_q[psic_pkg::PSIC_CTL_OE];
    wire logic ctl_even = ctl_q[psic_pkg::PSIC_CTL_EVEN];
    wire logic ctl_force = ctl_q[psic_pkg::PSIC_CTL_FORCE];

    // Event pulses: quality, energy and counter inputs direct, change detection on link, speed and duplex, rising edge only on aneg_done
    wire logic [psic_pkg::PSIC_EV_N-1:0] ev_pulse = {
        i_lq_event,
        i_ed_event,
        i_link.link_ok ^ link_q.link_ok,
        i_link.speed10 ^ link_q.speed10,
        i_link.full_duplex ^ link_q.full_duplex,
        i_link.aneg_done & ~link_q.aneg_done,
        i_ctr_half_event
    };

    // Status summary word; speed and duplex are passed through unqualified, the
    // host decides validity from link and negotiation state
    logic [15:0] sts_word;
    always_comb begin
        sts_word = 16'h0000;
        sts_word[psic_pkg::PSIC_STS_LINK] = i_link.link_ok;
        sts_word[psic_pkg::PSIC_STS_SPEED10] = i_link.speed10;
        sts_word[psic_pkg::PSIC_STS_DUPLEX] = i_link.full_duplex;
        sts_word[psic_pkg::PSIC_STS_ANEG] = i_link.aneg_done;
        sts_word[psic_pkg::PSIC_STS_PEND] = pend_q;
    end

    wire logic [15:0] ctl_word = {13'h0000, ctl_q};
    wire logic [15:0] ev_word = {ev_sts, 2'h0, ev_en};
    wire logic [15:0] rd_word =
        (hdr_reg == psic_pkg::PSIC_ADDR_STATUS) ? sts_word :
        (hdr_reg == psic_pkg::PSIC_ADDR_IRQCTL) ? ctl_word :
        (hdr_reg == psic_pkg::PSIC_ADDR_EVENT) ? ev_word : 16'h0000;
    wire logic ev_clear = rd_go && hdr_reg == psic_pkg::PSIC_ADDR_EVENT;
    wire logic ctl_we = wr_commit && regad_q == psic_pkg::PSIC_ADDR_IRQCTL;
    wire logic ev_we = wr_commit && regad_q == psic_pkg::PSIC_ADDR_EVENT;

    psic_event_bank #(
        .N(psic_pkg::PSIC_EV_N)
    ) u_events (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_event(ev_pulse),
        .i_clear(ev_clear),
        .i_en_we(ev_we),
        .i_en_wdata(wr_word[psic_pkg::PSIC_EV_EN_LSB +: psic_pkg::PSIC_EV_N]),
        .o_status(ev_sts),
        .o_enable(ev_en),
        .o_any(ev_any)
    );

    wire logic pend_d = ctl_force | (ctl_even & ev_any);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        sh_d = sh_q;
        mo_d = mo_q;
        moe_d = moe_q;
        if (mdc_rise) begin
            case (st_q)
                psic_pkg::PSIC_PRE: begin
                    if (mdio_s2_q) begin
                        if (cnt_q != psic_pkg::PSIC_PRE_LEN) begin
                            cnt_d = 6'(cnt_q + 6'h01);
                        end
                    end else if (cnt_q == psic_pkg::PSIC_PRE_LEN) begin
                        st_d = psic_pkg::PSIC_HDR;
                        cnt_d = 6'h00;
                        hdr_d = 13'h0000;
                    end else begin
                        cnt_d = 6'h00;
                    end
                end
                psic_pkg::PSIC_HDR: begin
                    hdr_d = hdr_full;
                    cnt_d = 6'(cnt_q + 6'h01);
                    if (hdr_done) begin
                        cnt_d = 6'h00;
                        st_d = (rd_go || wr_go) ? psic_pkg::PSIC_TA : psic_pkg::PSIC_PRE;
                        sh_d = rd_word;
                    end
                end
                psic_pkg::PSIC_TA: begin
                    if (cnt_q == 6'h00) begin
                        cnt_d = 6'h01;
                        moe_d = rd_q;
                        mo_d = 1'b0;
                    end else begin
                        cnt_d = psic_pkg::PSIC_DATA_LAST;
                        if (rd_q) begin
                            st_d = psic_pkg::PSIC_RDATA;
                            mo_d = sh_q[15];
                            sh_d = {sh_q[14:0], 1'b0};
                        end else begin
                            st_d = psic_pkg::PSIC_WDATA;
                        end
                    end
                end
                psic_pkg::PSIC_RDATA: begin
                    if (cnt_q == 6'h00) begin
                        st_d = psic_pkg::PSIC_PRE;
                        moe_d = 1'b0;
                        mo_d = 1'b0;
                    end else begin
                        cnt_d = 6'(cnt_q - 6'h01);
                        mo_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                    end
                end
                psic_pkg::PSIC_WDATA: begin
                    sh_d = wr_word;
                    cnt_d = 6'(cnt_q - 6'h01);
                    if (cnt_q == 6'h00) begin
                        st_d = psic_pkg::PSIC_PRE;
                    end
                end
                default: begin
                    st_d = psic_pkg::PSIC_PRE;
                    cnt_d = 6'h00;
                    moe_d = 1'b0;
                end
            endcase
            if (st_d == psic_pkg::PSIC_PRE && st_q != psic_pkg::PSIC_PRE) begin
                cnt_d = 6'h00;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st_q <= psic_pkg::PSIC_PRE;
            cnt_q <= 6'h00;
            hdr_q <= 13'h0000;
            sh_q <= 16'h0000;
            mo_q <= 1'b0;
            moe_q <= 1'b0;
            rd_q <= 1'b0;
            regad_q <= 5'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            sh_q <= sh_d;
            mo_q <= mo_d;
            moe_q <= moe_d;
            if (hdr_done) begin
                rd_q <= rd_go;
                regad_q <= hdr_reg;
            end
        end
    end

    // Only the three defined control bits are stored
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctl_q <= psic_pkg::PSIC_CTL_RST;
            link_q <= '0;
            pend_q <= 1'b0;
            pin_oe_q <= 1'b0;
            pdn_q <= 1'b0;
        end else begin
            if (ctl_we) begin
                ctl_q <= wr_word[psic_pkg::PSIC_CTL_W-1:0];
            end
            link_q <= i_link;
            pend_q <= pend_d;
            pin_oe_q <= ctl_oe & pend_d;
            pdn_q <= ~ctl_oe & ~pin_s2_q;
        end
    end

    assign o_mdio = mo_q;
    assign o_mdio_oe = moe_q;
    assign o_pin = 1'b0;
    assign o_pin_oe = pin_oe_q;
    assign o_powerdown_req = pdn_q;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    wire logic sts_rd = rd_go && hdr_reg == psic_pkg::PSIC_ADDR_STATUS;
    wire logic ctl_rd = rd_go && hdr_reg == psic_pkg::PSIC_ADDR_IRQCTL;

    a_duplex_bit: assert property (sts_rd |=> sh_q[2] == $past(i_link.full_duplex))
        else $error("duplex bit wrong in status word");
    a_speed_bit: assert property (sts_rd |=> sh_q[1] == $past(i_link.speed10))
        else $error("speed bit wrong in status word");
    a_link_bit: assert property (sts_rd |=> sh_q[0] == $past(i_link.link_ok))
        else $error("link bit wrong in status word");
    a_ctl_reserved: assert property (ctl_rd |=> sh_q[15:3] == 13'h0000)
        else $error("reserved control bits not zero");
    a_force_irq: assert property (ctl_force |=> pend_q)
        else $error("forced interrupt not pending");
    a_event_gate: assert property (!ctl_even && !ctl_force |=> !pend_q)
        else $error("event interrupt passed while disabled");
    a_pin_input: assert property (!ctl_oe |=> !o_pin_oe)
        else $error("pin driven while used as input");
    a_pin_low: assert property (ctl_oe && pend_d |=> o_pin_oe && !o_pin)
        else $error("pin not driven low on pending interrupt");
    a_read_clears: assert property (ev_clear && !(|ev_pulse) && !ctl_force
        |=> ##1 !pend_q)
        else $error("pending interrupt survived event read");

    c_forced: cover property (ctl_we && wr_word[psic_pkg::PSIC_CTL_FORCE]);
    c_event_rd: cover property (ev_clear && pend_q);
    c_pin_drive: cover property (o_pin_oe);
    c_powerdown: cover property (o_powerdown_req);

endmodule : psic_top

// ===== verilog/psic_pkg.sv
// Package with the register map, field positions, timing and types of the PHY status/irq block
package psic_pkg;

    // Management register addresses
    localparam logic [4:0] PSIC_ADDR_STATUS = 5'h10;
    localparam logic [4:0] PSIC_ADDR_IRQCTL = 5'h11;
    localparam logic [4:0] PSIC_ADDR_EVENT = 5'h12;

    // Status summary fields
    localparam int PSIC_STS_LINK = 0;
    localparam int PSIC_STS_SPEED10 = 1;
    localparam int PSIC_STS_DUPLEX = 2;
    localparam int PSIC_STS_ANEG = 4;
    localparam int PSIC_STS_PEND = 7;

    // Interrupt control fields and reset value
    localparam int PSIC_CTL_OE = 0;
    localparam int PSIC_CTL_EVEN = 1;
    localparam int PSIC_CTL_FORCE = 2;
    localparam int PSIC_CTL_W = 3;
    localparam logic [2:0] PSIC_CTL_RST = 3'h0;

    // Event register: status in the top bits, enables in the low bits
    localparam int PSIC_EV_N = 7;
    localparam int PSIC_EV_STS_LSB = 9;
    localparam int PSIC_EV_EN_LSB = 0;
    localparam logic [6:0] PSIC_EV_RST = 7'h00;

    // Management frame timing, in management clock periods, and frame opcodes
    localparam logic [5:0] PSIC_PRE_LEN = 6'h20;
    localparam logic [5:0] PSIC_HDR_LAST = 6'h0C;
    localparam logic [5:0] PSIC_DATA_LAST = 6'h0F;
    localparam logic [1:0] PSIC_OP_RD = 2'h2;
    localparam logic [1:0] PSIC_OP_WR = 2'h1;

    typedef enum logic [2:0] {
        PSIC_PRE = 3'h0,
        PSIC_HDR = 3'h1,
        PSIC_TA = 3'h3,
        PSIC_RDATA = 3'h2,
        PSIC_WDATA = 3'h6
    } psic_mdio_st_t;

    // Link state as resolved by negotiation or forced configuration
    typedef struct packed {
        logic link_ok;
        logic speed10;
        logic full_duplex;
        logic aneg_done;
    } psic_link_t;

endpackage : psic_pkg

// ===== verilog/psic_event_bank.sv
// Event status bits with clear-on-read and per-event enables
module psic_event_bank #(
    parameter int N = 7
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [N-1:0] i_event,
    input wire logic i_clear,
    input wire logic i_en_we,
    input wire logic [N-1:0] i_en_wdata,
    output logic [N-1:0] o_status,
    output logic [N-1:0] o_enable,
    output logic o_any
);

    logic [N-1:0] en_q;
    logic [N-1:0] sts_q;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_bit
            // A new event beats the read that clears the bit in the same cycle
            wire logic sts_d = i_event[gi] | (sts_q[gi] & ~i_clear);
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    sts_q[gi] <= 1'b0;
                end else begin
                    sts_q[gi] <= sts_d;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            en_q <= N'(0);
        end else if (i_en_we) begin
            en_q <= i_en_wdata;
        end
    end

    assign o_status = sts_q;
    assign o_enable = en_q;
    assign o_any = |(sts_q & en_q);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    a_status_sets: assert property (|i_event |=> |(o_status & $past(i_event)))
        else $error("event did not set its status bit");
    a_clear_empties: assert property (i_clear && !(|i_event) |=> o_status == N'(0))
        else $error("status not cleared by read");

endmodule : psic_event_bank

// ===== testbench/psic_irq_host.sv
// Host-side model of the shared power-down / interrupt pin with its pull-up
module psic_irq_host (
    input wire logic i_pin_oe,
    input wire logic i_pin,
    input wire logic i_pd_drive,
    output logic o_pin_level,
    output logic o_irq_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open-drain wire: either party pulls low, the pull-up holds it high otherwise
    assign o_pin_level = !(i_pin_oe && !i_pin) && !i_pd_drive;
    // Host never drives while it expects the interrupt role
    assign o_irq_seen = !o_pin_level && !i_pd_drive;
endmodule : psic_irq_host

// ===== testbench/psic_top_test.sv
// Self-checking bench for the PHY status summary and interrupt control block
module psic_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] PHY = 5'h03;
    logic clk_sys;
    logic rstn = 1'h0;
    logic mdc = 1'h0;
    logic mdio_q = 1'h1;
    logic mdio_out;
    logic mdio_oe;
    logic mdio_line;
    psic_pkg::psic_link_t link = '0;
    logic lq = 1'h0;
    logic ed = 1'h0;
    logic ctr = 1'h0;
    logic pin_level;
    logic pin_out;
    logic pin_oe;
    logic pd_req;
    logic pd_drive = 1'h0;
    logic irq_seen;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 55;

    // Pull-up on the management data line while the device is not driving
    assign mdio_line = mdio_oe ? mdio_out : mdio_q;

    psic_top #(.PHY_ADDR(PHY)) uut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_mdc(mdc),
        .i_mdio(mdio_line), .o_mdio(mdio_out), .o_mdio_oe(mdio_oe), .i_link(link),
        .i_lq_event(lq), .i_ed_event(ed), .i_ctr_half_event(ctr), .i_pin(pin_level),
        .o_pin(pin_out), .o_pin_oe(pin_oe), .o_powerdown_req(pd_req));

    psic_irq_host host (.i_pin_oe(pin_oe), .i_pin(pin_out), .i_pd_drive(pd_drive),
        .o_pin_level(pin_level), .o_irq_seen(irq_seen));

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic test_done();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // One whole frame; mdc phases of 5 clocks leave room for the 2-FF synchronisers
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'h1, op, PHY, ra,
                (op == psic_pkg::PSIC_OP_RD) ? {2'h3, 16'hFFFF} : {2'h2, wd}};
        for (int i = 0; i < 64; i++) begin
            mdio_q <= bits[63-i];
            mdc <= 1'h0;
            tick(5);
            if (i >= 48) begin
                rd[63-i] = mdio_line;
            end
            mdc <= 1'h1;
            tick(5);
        end
        mdc <= 1'h0;
        mdio_q <= 1'h1;
        tick(8);
    endtask : frame

    task automatic reg_wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] dummy;
        frame(psic_pkg::PSIC_OP_WR, ra, wd, dummy);
    endtask : reg_wr

    task automatic reg_rd(input logic [4:0] ra, output logic [15:0] rd);
        frame(psic_pkg::PSIC_OP_RD, ra, 16'h0000, rd);
    endtask : reg_rd

    // Speed and duplex are compared raw; the host qualifies them with link
    function automatic logic [15:0] status_exp(input psic_pkg::psic_link_t l, input logic p);
        return {8'h00, p, 2'h0, l.aneg_done, 1'h0, l.full_duplex, l.speed10, l.link_ok};
    endfunction : status_exp

    task automatic pulse_source(input int i);
        psic_pkg::psic_link_t l;
        l = link;
        case (i)
            0: lq <= 1'h1;
            1: ed <= 1'h1;
            2: l.link_ok = !l.link_ok;
            3: l.speed10 = !l.speed10;
            4: l.full_duplex = !l.full_duplex;
            5: l.aneg_done = 1'h1;
            default: ctr <= 1'h1;
        endcase
        link <= l;
        tick(1);
        lq <= 1'h0;
        ed <= 1'h0;
        ctr <= 1'h0;
    endtask : pulse_source

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end

    initial begin
        logic [15:0] rd;
        logic [15:0] w;
        logic pd;
        psic_pkg::psic_link_t lk;
        tick(4);
        rstn <= 1'h1;
        tick(3);
        check(pin_oe, 16'h0000, "pin enable after reset");
        reg_rd(psic_pkg::PSIC_ADDR_IRQCTL, rd);
        check(rd, 16'h0000, "control reset value");
        for (int n = 0; n < 6; n++) begin
            w = 16'($random(seed));
            lk = 4'($random(seed));
            pd = !w[0] && 1'($random(seed));
            link <= lk;
            pd_drive <= pd;
            reg_wr(psic_pkg::PSIC_ADDR_IRQCTL, w);
            reg_rd(psic_pkg::PSIC_ADDR_IRQCTL, rd);
            check(rd, {13'h0000, w[2:0]}, "control readback");
            check(pin_oe, 16'(w[0] & w[2]), "forced interrupt on pin");
            check(pd_req, 16'(pd), "power-down input role");
            reg_rd(psic_pkg::PSIC_ADDR_STATUS, rd);
            check(rd, status_exp(lk, w[2]), "status summary");
            reg_rd(psic_pkg::PSIC_ADDR_STATUS, rd);
            check(rd[0], lk.link_ok, "link kept after read");
        end
        // Status summary is read-only: a full write must leave it untouched
        reg_wr(psic_pkg::PSIC_ADDR_STATUS, 16'hFFFF);
        reg_rd(psic_pkg::PSIC_ADDR_STATUS, rd);
        check(rd, status_exp(lk, w[2]), "status ignores writes");
        pd_drive <= 1'h0;
        link <= '0;
        reg_wr(psic_pkg::PSIC_ADDR_EVENT, 16'h0040);
        reg_wr(psic_pkg::PSIC_ADDR_IRQCTL, 16'h0001);
        reg_rd(psic_pkg::PSIC_ADDR_EVENT, rd);
        pulse_source(0);
        tick(4);
        check(pin_oe, 16'h0000, "event gated by global enable");
        reg_wr(psic_pkg::PSIC_ADDR_IRQCTL, 16'h0003);
        check(pin_oe, 16'h0001, "event passes global enable");
        reg_rd(psic_pkg::PSIC_ADDR_EVENT, rd);
        check(rd, 16'h8040, "status and enable readback");
        check(pin_oe, 16'h0000, "pending cleared by read");
        for (int i = 0; i < 7; i++) begin
            reg_wr(psic_pkg::PSIC_ADDR_EVENT, 16'h0040 >> i);
            pulse_source(i);
            tick(4);
            check(pin_oe, 16'h0001, "event interrupt on pin");
            check(irq_seen, 16'h0001, "host sees interrupt");
            reg_rd(psic_pkg::PSIC_ADDR_EVENT, rd);
            check(rd, (16'h8000 >> i) | (16'h0040 >> i), "event status");
            check(pin_oe, 16'h0000, "pin released after read");
        end
        test_done();
    end
endmodule : psic_top_test
